// ---- hw/frs_fault_retry_sequencer.sv ----
// The address-and-strobe port and the register addresses were chosen for this implementation.
`default_nettype none
module frs_fault_retry_sequencer #(
    parameter int UNIT_CYC = frs_pkg::FRS_UNIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_fault,
    input wire logic [4:0] i_fault_class,
    input wire logic i_fault_injected,
    output logic o_fault_reset,
    output logic o_restart,
    output logic o_restart_flying,
    output logic o_fault_out,
    output logic o_retry_excess_fault,
    output logic o_retry_active_out
);
    typedef enum logic [3:0] {
        FRS_IDLE = 4'b0001,
        FRS_WAIT = 4'b0010,
        FRS_RUN = 4'b0100,
        FRS_TRIP = 4'b1000
    } frs_state_e;

    typedef struct packed {
        frs_state_e st;
        logic [2:0] flt_q;
        logic [9:0] cls_q;
        logic [1:0] inj_q;
        logic [2:0] sel;
        logic [6:0] lim;
        logic [6:0] dly;
        logic [15:0] coast;
        logic [7:0] fmap;
        logic [15:0] succ;
        logic [6:0] fails;
        logic [4:0] first;
        logic first_vld;
        logic [23:0] sub;
        logic [9:0] units;
        logic [15:0] rdata;
        logic fault_reset;
        logic restart;
        logic flying;
        logic fault_out;
        logic excess;
        logic active_raw;
        logic active;
    } frs_s;

    frs_s r_reg;
    frs_s r_next;

    // Eligibility of a fault class under a select value
    function automatic logic frs_eligible(input logic [2:0] sel,
                                          input logic [4:0] cls);
        logic [24:0] m;
        m = '0;
        case (sel)
            3'h0: m = frs_pkg::FRS_MASK0;
            3'h1: m = frs_pkg::FRS_MASK1;
            3'h2: m = frs_pkg::FRS_MASK2;
            3'h3: m = frs_pkg::FRS_MASK3;
            3'h4: m = frs_pkg::FRS_MASK4;
            3'h5: m = frs_pkg::FRS_MASK5;
            default: m = '0;
        endcase
        frs_eligible = (cls < 5'(frs_pkg::FRS_NCLASS)) ? m[cls] : 1'b0;
    endfunction

    logic lim_hi;
    logic [6:0] lim_eff;
    logic fault_s;
    logic fault_rise;
    logic [4:0] cls_s;
    logic inj_s;
    logic elig;
    logic [9:0] succ_units;

    // Decode of limit setting and fault eligibility
    always_comb begin
        lim_hi = (r_reg.lim >= frs_pkg::FRS_LIMIT_HI_MIN);
        lim_eff = lim_hi ? (r_reg.lim - frs_pkg::FRS_LIMIT_HI_OFS)
                         : r_reg.lim;
        fault_s = r_reg.flt_q[1];
        // A new fault in run is a rise of the synchronised level
        fault_rise = r_reg.flt_q[1] && !r_reg.flt_q[2];
        cls_s = r_reg.cls_q[9:5];
        inj_s = r_reg.inj_q[1];
        elig = frs_eligible(r_reg.sel, cls_s) && !inj_s;
        succ_units = 10'(r_reg.dly) * 10'(frs_pkg::FRS_SUCCESS_MULT);
    end

    // Next-state logic: registers, sequencer and outputs
    always_comb begin
        r_next = r_reg;
        // Two-stage synchronisers; flt_q[2] only feeds the edge detect
        r_next.flt_q = {r_reg.flt_q[1:0], i_fault};
        r_next.cls_q = {r_reg.cls_q[4:0], i_fault_class};
        r_next.inj_q = {r_reg.inj_q[0], i_fault_injected};
        r_next.fault_reset = 1'b0;
        r_next.restart = 1'b0;
        r_next.rdata = '0;
        // Unit timer runs in 100 ms ticks
        if (r_reg.sub == 24'(UNIT_CYC - 1)) begin
            r_next.sub = '0;
            if (r_reg.units != '1) begin
                r_next.units = r_reg.units + 10'h001;
            end
        end else begin
            r_next.sub = r_reg.sub + 24'h000001;
        end
        // Register writes; out-of-range values are ignored
        if (i_wr) begin
            case (i_addr)
                frs_pkg::FRS_ADDR_SELECT: begin
                    if (i_wdata[2:0] <= frs_pkg::FRS_SELECT_MAX &&
                        i_wdata[15:3] == '0) begin
                        r_next.sel = i_wdata[2:0];
                    end
                end
                frs_pkg::FRS_ADDR_LIMIT: begin
                    if (i_wdata[15:7] == '0 &&
                        (i_wdata[6:0] <= frs_pkg::FRS_LIMIT_LO_MAX ||
                        (i_wdata[6:0] >= frs_pkg::FRS_LIMIT_HI_MIN &&
                         i_wdata[6:0] <= frs_pkg::FRS_LIMIT_HI_MAX))) begin
                        r_next.lim = i_wdata[6:0];
                    end
                end
                frs_pkg::FRS_ADDR_DELAY: begin
                    if (i_wdata[15:7] == '0 &&
                        i_wdata[6:0] <= frs_pkg::FRS_DELAY_MAX) begin
                        r_next.dly = i_wdata[6:0];
                    end
                end
                frs_pkg::FRS_ADDR_SUCCESS: begin
                    if (i_wdata == '0) begin
                        r_next.succ = '0;
                    end
                end
                frs_pkg::FRS_ADDR_COAST: r_next.coast = i_wdata;
                frs_pkg::FRS_ADDR_FMAP: begin
                    if (i_wdata[7:0] == frs_pkg::FRS_FMAP_POS ||
                        i_wdata[7:0] == frs_pkg::FRS_FMAP_NEG) begin
                        r_next.fmap = i_wdata[7:0];
                    end
                end
                default: ;
            endcase
        end
        // Sequencer
        case (r_reg.st)
            FRS_IDLE: begin
                if (fault_s) begin
                    r_next.first = cls_s;
                    r_next.first_vld = 1'b1;
                    if (r_reg.lim != '0 && elig) begin
                        r_next.st = FRS_WAIT;
                        r_next.sub = '0;
                        r_next.units = '0;
                        r_next.active_raw = 1'b1;
                        r_next.fault_out = lim_hi;
                    end else begin
                        r_next.st = FRS_TRIP;
                        r_next.fault_out = 1'b1;
                    end
                end
            end
            FRS_WAIT: begin
                if (fault_s && !elig) begin
                    r_next.st = FRS_TRIP;
                    r_next.fault_out = 1'b1;
                    r_next.active_raw = 1'b0;
                end else if (r_reg.units >= 10'(r_reg.dly)) begin
                    r_next.st = FRS_RUN;
                    r_next.fault_reset = 1'b1;
                    r_next.restart = 1'b1;
                    r_next.sub = '0;
                    r_next.units = '0;
                    r_next.fails = r_reg.fails + 7'h01;
                    r_next.fault_out = 1'b0;
                end
            end
            FRS_RUN: begin
                // Old fault lingers in the synchroniser; only a rise counts
                if (fault_rise) begin
                    if (r_reg.fails >= lim_eff || !elig) begin
                        r_next.st = FRS_TRIP;
                        r_next.fault_out = 1'b1;
                        r_next.excess = elig;
                        r_next.active_raw = 1'b0;
                    end else begin
                        r_next.st = FRS_WAIT;
                        r_next.sub = '0;
                        r_next.units = '0;
                        r_next.fault_out = lim_hi;
                    end
                end else if (!fault_s &&
                             (r_reg.units > succ_units ||
                              (r_reg.units == succ_units &&
                               r_reg.sub != '0))) begin
                    r_next.st = FRS_IDLE;
                    r_next.succ = r_reg.succ + 16'h0001;
                    r_next.fails = '0;
                    r_next.active_raw = 1'b0;
                    r_next.first_vld = 1'b0;
                end
            end
            FRS_TRIP: begin
                // Leaves only after outside reset clears the fault
                if (!fault_s && !inj_s) begin
                    r_next.st = FRS_IDLE;
                    r_next.fault_out = 1'b0;
                    r_next.excess = 1'b0;
                    r_next.fails = '0;
                    r_next.first_vld = 1'b0;
                end
            end
            default: r_next.st = FRS_IDLE;
        endcase
        r_next.flying = (r_reg.coast != frs_pkg::FRS_COAST_OFF);
        r_next.active = (r_reg.fmap == frs_pkg::FRS_FMAP_NEG)
                        ? !r_next.active_raw : r_next.active_raw;
        // Read data, one cycle later
        if (i_rd) begin
            case (i_addr)
                frs_pkg::FRS_ADDR_SELECT: r_next.rdata = 16'(r_reg.sel);
                frs_pkg::FRS_ADDR_LIMIT: r_next.rdata = 16'(r_reg.lim);
                frs_pkg::FRS_ADDR_DELAY: r_next.rdata = 16'(r_reg.dly);
                frs_pkg::FRS_ADDR_SUCCESS: r_next.rdata = r_reg.succ;
                frs_pkg::FRS_ADDR_COAST: r_next.rdata = r_reg.coast;
                frs_pkg::FRS_ADDR_STATUS:
                    r_next.rdata = {5'h00, r_reg.fails, r_reg.st};
                frs_pkg::FRS_ADDR_FIRST:
                    r_next.rdata = {10'h000, r_reg.first_vld, r_reg.first};
                frs_pkg::FRS_ADDR_FMAP: r_next.rdata = 16'(r_reg.fmap);
                default: r_next.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_reg <= '{st: FRS_IDLE, flt_q: 3'h0, cls_q: 10'h000,
                       inj_q: 2'h0,
                       sel: frs_pkg::FRS_SELECT_RST,
                       lim: frs_pkg::FRS_LIMIT_RST,
                       dly: frs_pkg::FRS_DELAY_RST,
                       coast: frs_pkg::FRS_COAST_RST,
                       fmap: frs_pkg::FRS_FMAP_RST,
                       succ: 16'h0000, fails: 7'h00, first: 5'h00,
                       first_vld: 1'b0, sub: 24'h000000, units: 10'h000,
                       rdata: 16'h0000, fault_reset: 1'b0, restart: 1'b0,
                       flying: 1'b0, fault_out: 1'b0, excess: 1'b0,
                       active_raw: 1'b0, active: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata = r_reg.rdata;
    assign o_fault_reset = r_reg.fault_reset;
    assign o_restart = r_reg.restart;
    assign o_restart_flying = r_reg.flying;
    assign o_fault_out = r_reg.fault_out;
    assign o_retry_excess_fault = r_reg.excess;
    assign o_retry_active_out = r_reg.active;
endmodule // frs_fault_retry_sequencer
`default_nettype wire

// ---- shared/frs_pkg.sv ----
`default_nettype none
package frs_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] FRS_ADDR_SELECT = 4'h0;
    localparam logic [3:0] FRS_ADDR_LIMIT = 4'h1;
    localparam logic [3:0] FRS_ADDR_DELAY = 4'h2;
    localparam logic [3:0] FRS_ADDR_SUCCESS = 4'h3;
    localparam logic [3:0] FRS_ADDR_COAST = 4'h4;
    localparam logic [3:0] FRS_ADDR_STATUS = 4'h5;
    localparam logic [3:0] FRS_ADDR_FIRST = 4'h6;
    localparam logic [3:0] FRS_ADDR_FMAP = 4'h7;
    // Reset values
    localparam logic [2:0] FRS_SELECT_RST = 3'h0;
    localparam logic [6:0] FRS_LIMIT_RST = 7'h00;
    localparam logic [6:0] FRS_DELAY_RST = 7'h0a;   // 1 s in 0.1 s units
    localparam logic [15:0] FRS_COAST_RST = 16'h270f; // 9999, disabled
    localparam logic [7:0] FRS_FMAP_RST = 8'h40;     // 64, positive logic
    // Setting ranges
    localparam logic [2:0] FRS_SELECT_MAX = 3'h5;
    localparam logic [6:0] FRS_LIMIT_LO_MAX = 7'h0a;   // 10
    localparam logic [6:0] FRS_LIMIT_HI_MIN = 7'h65;   // 101
    localparam logic [6:0] FRS_LIMIT_HI_MAX = 7'h6e;   // 110
    localparam logic [6:0] FRS_LIMIT_HI_OFS = 7'h64;   // 100
    localparam logic [6:0] FRS_DELAY_MAX = 7'h64;      // 10 s
    localparam logic [15:0] FRS_COAST_OFF = 16'h270f;  // 9999
    localparam logic [7:0] FRS_FMAP_POS = 8'h40;       // 64
    localparam logic [7:0] FRS_FMAP_NEG = 8'ha4;       // 164
    localparam logic [2:0] FRS_SUCCESS_MULT = 3'h4;
    // Time base: one delay unit is 100 ms at 40 MHz
    localparam int FRS_CLK_HZ = 40000000;
    localparam int FRS_UNIT_MS = 100;
    localparam int FRS_UNIT_CYC = FRS_CLK_HZ / 1000 * FRS_UNIT_MS;
    // Fault class encoding on i_fault_class
    localparam int FRS_NCLASS = 25;
    // Eligibility masks, one bit per fault class, index 0 = class 0
    localparam logic [24:0] FRS_MASK0 = 25'h1ffffff;
    localparam logic [24:0] FRS_MASK1 = 25'h0000007;
    localparam logic [24:0] FRS_MASK2 = 25'h0000038;
    localparam logic [24:0] FRS_MASK3 = 25'h000003f;
    localparam logic [24:0] FRS_MASK4 = 25'h1fbef3f;
    localparam logic [24:0] FRS_MASK5 = 25'h0000005;
endpackage : frs_pkg
`default_nettype wire

// ---- tb/frs_fault_retry_sequencer_asserts.sv ----
`default_nettype none
module frs_retry_checker (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_rd,
    input wire logic i_fault,
    input wire logic i_fault_injected,
    input wire logic [15:0] o_rdata,
    input wire logic o_fault_reset,
    input wire logic o_restart,
    input wire logic o_fault_out,
    input wire logic o_retry_excess_fault,
    input wire logic o_retry_active_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // All checks run on the system clock
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    property p_restart_pair;
        o_fault_reset |-> o_restart;
    endproperty
    a_restart_pair: assert property (p_restart_pair)
        else $error("restart not paired with fault reset");
    property p_reset_pulse;
        o_fault_reset |=> !o_fault_reset;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("fault reset longer than one cycle");
    property p_rdata_zero;
        !$past(i_rd) |-> o_rdata == 16'h0000;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero)
        else $error("read data outside its slot");
    property p_excess_trip;
        o_retry_excess_fault |-> o_fault_out && !o_restart;
    endproperty
    a_excess_trip: assert property (p_excess_trip)
        else $error("excess fault without trip");
    property p_inject_none;
        $rose(i_fault) && i_fault_injected |=> !o_restart [*8];
    endproperty
    a_inject_none: assert property (p_inject_none)
        else $error("injected fault restarted");
    property p_inject_trip;
        $rose(i_fault) && i_fault_injected |-> ##[1:6] o_fault_out;
    endproperty
    a_inject_trip: assert property (p_inject_trip)
        else $error("injected fault gave no trip");
    property p_active_on;
        o_restart |-> o_retry_active_out;
    endproperty
    a_active_on: assert property (p_active_on)
        else $error("active output low at restart");
    property p_active_wait;
        o_restart |-> $past(o_retry_active_out, 1);
    endproperty
    a_active_wait: assert property (p_active_wait)
        else $error("active output low while waiting");
endmodule // frs_retry_checker
`default_nettype wire

// ---- tb/frs_drive_model.sv ----
`default_nettype none
module frs_drive_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_trip,
    input wire logic i_clear,
    input wire logic [4:0] i_cls,
    input wire logic i_inj,
    input wire logic i_fault_reset,
    output logic o_fault,
    output logic [4:0] o_cls,
    output logic o_inj
);
    timeunit 1ns;
    timeprecision 100ps;
    // Fault held until reset pulse or outside clear; class junk when idle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fault <= 1'b0;
            o_cls <= 5'h00;
            o_inj <= 1'b0;
        end else if (i_trip) begin
            o_fault <= 1'b1;
            o_cls <= i_cls;
            o_inj <= i_inj;
        end else if (i_fault_reset || i_clear || !o_fault) begin
            o_fault <= 1'b0;
            o_cls <= ~o_cls;
            o_inj <= 1'b0;
        end
    end
endmodule // frs_drive_model
`default_nettype wire

// ---- tb/frs_fault_retry_sequencer_tb.sv ----
`default_nettype none
module frs_fault_retry_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata, d;
    logic flt, inj, frst, rst, fly, fout, exc, act;
    logic t_trip = 1'b0, t_clr = 1'b0, t_inj = 1'b0;
    logic [4:0] cls, t_cls = 5'h00;
    int n_fail = 0, check_count = 0, cyc = 0, n, k;
    logic [15:0] rst_tab [9] = '{16'h0000, 16'h0000, 16'h000a,
        16'h0000, 16'h270f, 16'h0001, 16'h0000, 16'h0040, 16'h0000};
    frs_fault_retry_sequencer #(.UNIT_CYC(10)) i_dut (.i_clk(i_clk),
        .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fault(flt),
        .i_fault_class(cls), .i_fault_injected(inj),
        .o_fault_reset(frst), .o_restart(rst), .o_restart_flying(fly),
        .o_fault_out(fout), .o_retry_excess_fault(exc),
        .o_retry_active_out(act));
    frs_drive_model i_drv (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_trip(t_trip), .i_clear(t_clr), .i_cls(t_cls), .i_inj(t_inj),
        .i_fault_reset(frst), .o_fault(flt), .o_cls(cls), .o_inj(inj));
    // Clock and hang guard
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask
    task automatic trip(input logic [4:0] c, input logic j);
        @(posedge i_clk);
        t_trip <= 1'b1;
        t_cls <= c;
        t_inj <= j;
        @(posedge i_clk);
        t_trip <= 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
    endtask
    task automatic clear();
        @(posedge i_clk);
        t_clr <= 1'b1;
        @(posedge i_clk);
        t_clr <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic wait_rs(input int cap);
        for (n = 0; n < cap; n++) begin
            @(posedge i_clk);
            #1;
            if (rst === 1'b1) break;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (k = 0; k < 9; k++) begin
            rd(k[3:0], d);
            chk("reset value", rst_tab[k], d);
        end
        wr(4'h0, 16'h0006);
        rd(4'h0, d);
        chk("select", 16'h0000, d);
        trip(5'h00, 1'b0);
        chk("fault_out", 16'h0001, 16'(fout));
        wait_rs(40);
        chk("no restart", 16'd40, 16'(n));
        clear();
        // Retry that succeeds, polarity and restart style on the way
        wr(4'h1, 16'h0001);
        wr(4'h2, 16'h0002);
        wr(4'h4, 16'h0000);
        wr(4'h7, 16'h00a4);
        repeat (2) @(posedge i_clk);
        #1;
        chk("active inverted", 16'h0001, 16'(act));
        wr(4'h7, 16'h0040);
        trip(5'h06, 1'b0);
        chk("fault_out", 16'h0000, 16'(fout));
        chk("active", 16'h0001, 16'(act));
        wait_rs(60);
        chk("wait", 16'h0001, 16'(n + 7 >= 20 && n + 7 <= 26));
        chk("flying", 16'h0001, 16'(fly));
        repeat (100) @(posedge i_clk);
        rd(4'h3, d);
        chk("success", 16'h0001, d);
        rd(4'h5, d);
        chk("fails", 16'h0000, 16'(d[10:4]));
        chk("active off", 16'h0000, 16'(act));
        wr(4'h4, 16'h270f);
        repeat (2) @(posedge i_clk);
        #1;
        chk("flying off", 16'h0000, 16'(fly));
        // Ineligible class, then injected eligible class
        wr(4'h0, 16'h0004);
        for (k = 0; k < 2; k++) begin
            trip(k ? 5'h00 : 5'h0c, k[0]);
            chk("fault_out", 16'h0001, 16'(fout));
            wait_rs(40);
            chk("no restart", 16'd40, 16'(n));
            clear();
        end
        wr(4'h3, 16'h0005);
        rd(4'h3, d);
        chk("success kept", 16'h0001, d);
        wr(4'h3, 16'h0000);
        rd(4'h3, d);
        chk("success clear", 16'h0000, d);
        // Failed retry runs into the excess fault
        wr(4'h1, 16'h0065);
        trip(5'h03, 1'b0);
        chk("fault_out", 16'h0001, 16'(fout));
        wait_rs(60);
        chk("restart", 16'h0001, 16'(rst));
        repeat (3) @(posedge i_clk);
        trip(5'h05, 1'b0);
        chk("excess", 16'h0001, 16'(exc));
        chk("fault_out", 16'h0001, 16'(fout));
        rd(4'h6, d);
        chk("first fault", 16'h0023, d);
        clear();
        complete_run();
    end
endmodule // frs_fault_retry_sequencer_tb
bind frs_fault_retry_sequencer frs_retry_checker u_chk (.i_clk, .i_resetn,
    .i_rd, .i_fault, .i_fault_injected, .o_rdata, .o_fault_reset,
    .o_restart, .o_fault_out, .o_retry_excess_fault, .o_retry_active_out);
`default_nettype wire
